// File: pkg/rtio_pkg.sv
// Constants, field layouts and state types of the external trigger I/O block
package rtio_pkg;

   // ************************************************************
   // Timing
   // ************************************************************
   localparam int unsigned CLK_NS          = 25;
   localparam int unsigned SYNC_CYC        = 2;
   localparam int unsigned TB_MIN_NS       = 100;
   localparam int unsigned TRIG_MIN_NS     = 500;
   localparam int unsigned EDGE_MIN_NS     = 200;
   localparam int unsigned TB_FILT_CYC     = TB_MIN_NS / CLK_NS - 1;
   localparam int unsigned TRIG_FILT_CYC   = TRIG_MIN_NS / CLK_NS - 1;
   localparam int unsigned EDGE_FILT_CYC   = EDGE_MIN_NS / CLK_NS - 1;
   localparam int unsigned TB_LAT_NS       = 350;
   // Sync and filter already spend part of the latency
   localparam int unsigned TB_LAT_CYC      = (TB_LAT_NS + CLK_NS - 1) / CLK_NS
                                             - SYNC_CYC - TB_FILT_CYC - 1;
   localparam int unsigned GRID_NS_DEF     = 60;
   localparam int unsigned TS_RES_NS       = 50;
   localparam int unsigned TS_DIV_CYC      = TS_RES_NS / CLK_NS;
   localparam int unsigned PULSE_NS        = 12500;
   localparam int unsigned PULSE_CYC       = (PULSE_NS + CLK_NS - 1) / CLK_NS;
   localparam int unsigned US_NS           = 1000;
   localparam int unsigned US_CYC          = US_NS / CLK_NS;
   localparam int unsigned DLY_DEF_US      = 516;
   localparam int unsigned DLY_BIN_US      = 504;
   localparam int unsigned REC_RESP_NS     = 1000000000;
   localparam int unsigned REC_RESP_CYC_DEF = REC_RESP_NS / CLK_NS;

   // ************************************************************
   // Register map
   // ************************************************************
   localparam logic [7:0] CTRL_OFS   = 8'h00;
   localparam logic [7:0] DELAY_OFS  = 8'h04;
   localparam logic [7:0] STAT_OFS   = 8'h08;
   localparam logic [7:0] MASK_OFS   = 8'h0C;
   localparam logic [7:0] TSTAMP_OFS = 8'h10;
   localparam int unsigned CTRL_W    = 9;
   localparam int unsigned DLY_W     = 16;
   localparam int unsigned ST_W      = 5;
   localparam int unsigned ST_TRIG   = 0;
   localparam int unsigned ST_START  = 1;
   localparam int unsigned ST_STOP   = 2;
   localparam int unsigned ST_TDC    = 3;
   localparam int unsigned ST_TOUT   = 4;
   localparam int unsigned STAT_REC_BIT  = 8;
   localparam int unsigned STAT_BUSY_BIT = 9;

   typedef enum logic [1:0] {
      TOUT_HIGH = 2'h0,
      TOUT_LOW  = 2'h1,
      TOUT_HOLD = 2'h2
   } rtio_tout_e;

   typedef enum logic [3:0] {
      REC_IDLE     = 4'h1,
      REC_STARTING = 4'h2,
      REC_RUN      = 4'h4,
      REC_STOPPING = 4'h8
   } rtio_rec_e;

   // Bit 0 is trig_fall
   typedef struct packed {
      logic       tdc_en;
      logic       alarm_pol;
      logic       ev_rec;
      rtio_tout_e tout_mode;
      logic       fwd_en;
      logic       stop_fall;
      logic       start_fall;
      logic       trig_fall;
   } rtio_ctrl_s;

   localparam logic [CTRL_W-1:0] CTRL_RST = 9'h080;

   typedef struct packed {
      logic       s1;
      logic       s2;
      logic       lvl;
      logic       rise;
      logic       fall;
      logic [7:0] cnt;
   } rtio_filt_s;

   typedef struct packed {
      rtio_ctrl_s              ctrl;
      logic [DLY_W-1:0]        dly_us;
      logic [ST_W-1:0]         mask;
      logic [ST_W-1:0]         stat;
      logic                    pready;
      logic                    pslverr;
      logic [31:0]             prdata;
      logic                    irq;
      logic [TB_LAT_CYC-1:0]   tb_pipe;
      logic                    tb_pend;
      logic [7:0]              grid_cnt;
      logic                    sample;
      logic [1:0]              ts_div;
      logic [31:0]             ts_cnt;
      logic [31:0]             tstamp;
      logic                    trig_mark;
      logic                    tdc;
      logic                    tout_busy;
      logic [23:0]             tout_cnt;
      logic                    tout_act;
      logic [9:0]              pulse_cnt;
      logic                    hold;
      logic                    tout_pin;
      logic                    ev_busy;
      logic [23:0]             ev_cnt;
      logic                    ev_pend;
      logic                    ev_lvl;
      logic                    ev_pin;
      rtio_rec_e               rec_st;
      logic [31:0]             rec_cnt;
      logic                    rec;
   } rtio_top_s;

endpackage

// File: hw/rtio_top.sv
// External trigger, time base, start/stop and event I/O with APB registers
`timescale 1ns/100ps
`default_nettype none


// ************************************************************
// Synchroniser and pulse width filter for one pin
// ************************************************************
module rtio_filt #(
   parameter int unsigned FILT = 3
) (
   input  wire logic clk_i,
   input  wire logic rst_i,
   input  wire logic pin_i,
   output var  logic rise_o,
   output var  logic fall_o
);
   localparam rtio_pkg::rtio_filt_s FILT_RST = '{s1: 1'b1, s2: 1'b1, lvl: 1'b1, default: '0};
   localparam logic [7:0] FILT_LAST = 8'(FILT - 1);

   rtio_pkg::rtio_filt_s r;
   rtio_pkg::rtio_filt_s next;

   if (FILT < 1 || FILT > 255) begin : g_chk
      $error("rtio_filt: FILT out of range");
   end

   always_comb begin
      next      = r;
      next.s1   = pin_i;
      next.s2   = r.s1;
      next.rise = 1'b0;
      next.fall = 1'b0;
      // Level must differ for FILT cycles before it is taken
      if (r.s2 == r.lvl) begin
         next.cnt = 8'h00;
      end else if (r.cnt == FILT_LAST) begin
         next.cnt  = 8'h00;
         next.lvl  = r.s2;
         next.rise = r.s2;
         next.fall = !r.s2;
      end else begin
         next.cnt = r.cnt + 8'h01;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         r <= FILT_RST;
      end else begin
         r <= next;
      end
   end

   assign rise_o = r.rise;
   assign fall_o = r.fall;

   AST_FILT_STABLE: assert property (@(posedge clk_i) disable iff (rst_i)
      $changed(r.lvl) |-> $past(r.cnt) == FILT_LAST && $past(r.s2) == r.lvl)
      else $error("Filter level changed without a full stable window");
endmodule

// ************************************************************
// Top
// ************************************************************
module rtio_top #(
   parameter int unsigned GRID_NS      = rtio_pkg::GRID_NS_DEF,
   parameter int unsigned REC_RESP_CYC = rtio_pkg::REC_RESP_CYC_DEF
) (
   input  wire logic        SYS_CLK_I,
   input  wire logic        SYS_RST_I,
   input  wire logic        PSEL_I,
   input  wire logic        PENABLE_I,
   input  wire logic        PWRITE_I,
   input  wire logic [7:0]  PADDR_I,
   input  wire logic [31:0] PWDATA_I,
   output var  logic [31:0] PRDATA_O,
   output var  logic        PREADY_O,
   output var  logic        PSLVERR_O,
   input  wire logic        EXT_TB_I,
   input  wire logic        EXT_TRIG_I,
   input  wire logic        EXT_START_I,
   input  wire logic        EXT_STOP_I,
   input  wire logic        TRIG_I,
   input  wire logic        ALARM_I,
   input  wire logic        AUTO_I,
   output var  logic        SAMPLE_O,
   output var  logic        TRIG_MARK_O,
   output var  logic        TDC_O,
   output var  logic        REC_O,
   output var  logic        TRIG_OUT_O,
   output var  logic        EVENT_OUT_O,
   output var  logic        IRQ_O
);
   localparam int unsigned GRID_CYC = (GRID_NS + rtio_pkg::CLK_NS - 1) / rtio_pkg::CLK_NS;
   localparam int unsigned LAT = rtio_pkg::TB_LAT_CYC;
   localparam logic [7:0]  GRID_LAST = 8'(GRID_CYC - 1);
   localparam int unsigned FILT_TAB [4] = '{rtio_pkg::TB_FILT_CYC, rtio_pkg::TRIG_FILT_CYC,
                                           rtio_pkg::EDGE_FILT_CYC, rtio_pkg::EDGE_FILT_CYC};
   localparam rtio_pkg::rtio_top_s TOP_RST = '{
      ctrl:   rtio_pkg::CTRL_RST,
      dly_us: 16'(rtio_pkg::DLY_DEF_US),
      rec_st: rtio_pkg::REC_IDLE,
      default: '0};

   if (GRID_CYC < 1 || GRID_CYC > 255 || REC_RESP_CYC < 1) begin : g_chk
      $error("rtio_top: GRID_NS or REC_RESP_CYC out of range");
   end

   rtio_pkg::rtio_top_s r;
   rtio_pkg::rtio_top_s next;
   logic [3:0]          f_rise;
   logic [3:0]          f_fall;
   logic [3:0]          pins;
   logic                acc;
   logic                done;
   logic                trig_ev;
   logic                start_ev;
   logic                stop_ev;
   logic                tout_start;
   logic                tout_fire;
   logic                ev_src;
   logic [23:0]         dly_cyc;
   logic [23:0]         ev_dly;
   logic [4:0]          st_set;
   logic [4:0]          st_clr;

   assign pins = {EXT_STOP_I, EXT_START_I, EXT_TRIG_I, EXT_TB_I};

   for (genvar i = 0; i < 4; i++) begin : g_filt
      rtio_filt #(.FILT(FILT_TAB[i])) u_filt (
         .clk_i  (SYS_CLK_I),
         .rst_i  (SYS_RST_I),
         .pin_i  (pins[i]),
         .rise_o (f_rise[i]),
         .fall_o (f_fall[i])
      );
   end

   always_comb begin
      next     = r;
      acc      = PSEL_I & PENABLE_I & !r.pready;
      done     = PSEL_I & PENABLE_I & r.pready;
      trig_ev  = r.ctrl.trig_fall ? f_fall[1] : f_rise[1];
      start_ev = r.ctrl.start_fall ? f_fall[2] : f_rise[2];
      stop_ev  = r.ctrl.stop_fall ? f_fall[3] : f_rise[3];
      dly_cyc  = 24'(r.dly_us) * 24'(rtio_pkg::US_CYC);
      ev_dly   = (r.dly_us == 16'h0000) ? 24'h000000 :
                 24'(r.dly_us - 16'h0001) * 24'(rtio_pkg::US_CYC);

      // ************************************************************
      // APB slave: one wait state, read data captured with pready
      // ************************************************************
      next.pready  = acc;
      next.pslverr = 1'b0;
      if (acc) begin
         next.prdata = 32'h00000000;
         case (PADDR_I)
            rtio_pkg::CTRL_OFS:   next.prdata[rtio_pkg::CTRL_W-1:0] = r.ctrl;
            rtio_pkg::DELAY_OFS:  next.prdata[rtio_pkg::DLY_W-1:0] = r.dly_us;
            rtio_pkg::STAT_OFS: begin
               next.prdata[rtio_pkg::ST_W-1:0]       = r.stat;
               next.prdata[rtio_pkg::STAT_REC_BIT]  = r.rec;
               next.prdata[rtio_pkg::STAT_BUSY_BIT] = r.tout_busy;
            end
            rtio_pkg::MASK_OFS:   next.prdata[rtio_pkg::ST_W-1:0] = r.mask;
            rtio_pkg::TSTAMP_OFS: next.prdata = r.tstamp;
            default:              next.pslverr = 1'b1;
         endcase
      end
      if (done && PWRITE_I) begin
         case (PADDR_I)
            rtio_pkg::CTRL_OFS:  next.ctrl = rtio_pkg::rtio_ctrl_s'(PWDATA_I[rtio_pkg::CTRL_W-1:0]);
            rtio_pkg::DELAY_OFS: next.dly_us = PWDATA_I[rtio_pkg::DLY_W-1:0];
            rtio_pkg::MASK_OFS:  next.mask = PWDATA_I[rtio_pkg::ST_W-1:0];
            default:             next.mask = r.mask;
         endcase
      end

      // ************************************************************
      // Time base: fixed latency, then next grid tick
      // ************************************************************
      next.tb_pipe  = {r.tb_pipe[LAT-2:0], f_rise[0]};
      next.grid_cnt = (r.grid_cnt == GRID_LAST) ? 8'h00 : r.grid_cnt + 8'h01;
      // Edges closer than one grid step merge into one sample
      next.sample   = r.tb_pend & (r.grid_cnt == 8'h00);
      next.tb_pend  = r.tb_pipe[LAT-1] | (r.tb_pend & (r.grid_cnt != 8'h00));

      // ************************************************************
      // Trigger input: stamp, mark, top dead centre
      // ************************************************************
      next.ts_div = (r.ts_div == 2'(rtio_pkg::TS_DIV_CYC - 1)) ? 2'h0 : r.ts_div + 2'h1;
      if (r.ts_div == 2'(rtio_pkg::TS_DIV_CYC - 1)) begin
         next.ts_cnt = r.ts_cnt + 32'h00000001;
      end
      next.trig_mark = trig_ev & !r.ctrl.tdc_en;
      next.tdc       = trig_ev & r.ctrl.tdc_en;
      if (trig_ev && !r.ctrl.tdc_en) begin
         next.tstamp = r.ts_cnt;
      end

      // ************************************************************
      // Trigger output
      // ************************************************************
      // One trigger in flight; later ones are dropped until it ends
      tout_start = ((trig_ev & !r.ctrl.tdc_en & r.ctrl.fwd_en) | TRIG_I)
                   & !r.tout_busy & !r.tout_act & !r.hold;
      tout_fire  = r.tout_busy & (r.tout_cnt == 24'h000000);
      if (tout_start) begin
         next.tout_busy = 1'b1;
         next.tout_cnt  = dly_cyc;
      end else if (tout_fire) begin
         next.tout_busy = 1'b0;
         if (r.ctrl.tout_mode == rtio_pkg::TOUT_HOLD) begin
            next.hold = r.rec;
         end else begin
            next.tout_act  = 1'b1;
            next.pulse_cnt = 10'(rtio_pkg::PULSE_CYC - 1);
         end
      end else if (r.tout_busy) begin
         next.tout_cnt = r.tout_cnt - 24'h000001;
      end
      if (r.tout_act) begin
         if (r.pulse_cnt == 10'h000) begin
            next.tout_act = 1'b0;
         end else begin
            next.pulse_cnt = r.pulse_cnt - 10'h001;
         end
      end
      if (!r.rec) begin
         next.hold = 1'b0;
      end
      case (r.ctrl.tout_mode)
         rtio_pkg::TOUT_HIGH: next.tout_pin = next.tout_act;
         rtio_pkg::TOUT_LOW:  next.tout_pin = !next.tout_act;
         rtio_pkg::TOUT_HOLD: next.tout_pin = next.hold;
         default:             next.tout_pin = next.tout_act;
      endcase

      // ************************************************************
      // Event output: one pending change; blips that come and go during its delay are lost
      // ************************************************************
      ev_src = r.ctrl.ev_rec ? r.rec : ALARM_I;
      if (!r.ev_busy && ev_src != r.ev_pend) begin
         next.ev_pend = ev_src;
         next.ev_busy = 1'b1;
         next.ev_cnt  = ev_dly;
      end else if (r.ev_busy) begin
         if (r.ev_cnt == 24'h000000) begin
            next.ev_lvl  = r.ev_pend;
            next.ev_busy = 1'b0;
         end else begin
            next.ev_cnt = r.ev_cnt - 24'h000001;
         end
      end
      next.ev_pin = r.ctrl.ev_rec ? next.ev_lvl : (next.ev_lvl ~^ r.ctrl.alarm_pol);

      // ************************************************************
      // Recording control
      // ************************************************************
      case (r.rec_st)
         rtio_pkg::REC_IDLE: begin
            if (start_ev) begin
               next.rec_st  = rtio_pkg::REC_STARTING;
               next.rec_cnt = 32'(REC_RESP_CYC - 1);
            end
         end
         rtio_pkg::REC_STARTING: begin
            if (r.rec_cnt == 32'h00000000) begin
               next.rec_st = rtio_pkg::REC_RUN;
            end else begin
               next.rec_cnt = r.rec_cnt - 32'h00000001;
            end
         end
         rtio_pkg::REC_RUN: begin
            if (stop_ev && !AUTO_I) begin
               next.rec_st  = rtio_pkg::REC_STOPPING;
               next.rec_cnt = 32'(REC_RESP_CYC - 1);
            end
         end
         rtio_pkg::REC_STOPPING: begin
            if (r.rec_cnt == 32'h00000000) begin
               next.rec_st = rtio_pkg::REC_IDLE;
            end else begin
               next.rec_cnt = r.rec_cnt - 32'h00000001;
            end
         end
         default: next.rec_st = rtio_pkg::REC_IDLE;
      endcase
      next.rec = (next.rec_st == rtio_pkg::REC_RUN) || (next.rec_st == rtio_pkg::REC_STOPPING);

      // ************************************************************
      // Sticky status; read clears only bits it reported, set wins
      // ************************************************************
      st_set = {tout_fire, trig_ev & r.ctrl.tdc_en, stop_ev, start_ev, trig_ev & !r.ctrl.tdc_en};
      st_clr = (done && !PWRITE_I && PADDR_I == rtio_pkg::STAT_OFS) ?
               r.prdata[rtio_pkg::ST_W-1:0] : 5'h00;
      next.stat = (r.stat & ~st_clr) | st_set;
      next.irq  = |(r.stat & r.mask);
   end

   always_ff @(posedge SYS_CLK_I) begin
      if (SYS_RST_I) begin
         r <= TOP_RST;
      end else begin
         r <= next;
      end
   end

   assign PRDATA_O    = r.prdata;
   assign PREADY_O    = r.pready;
   assign PSLVERR_O   = r.pslverr;
   assign SAMPLE_O    = r.sample;
   assign TRIG_MARK_O = r.trig_mark;
   assign TDC_O       = r.tdc;
   assign REC_O       = r.rec;
   assign TRIG_OUT_O  = r.tout_pin;
   assign EVENT_OUT_O = r.ev_pin;
   assign IRQ_O       = r.irq;

   // ************************************************************
   // Checks
   // ************************************************************
   localparam int AST_TB_MIN = rtio_pkg::TB_LAT_CYC + 2;
   localparam int AST_TB_MAX = rtio_pkg::TB_LAT_CYC + GRID_CYC + 1;
   logic [10:0] ast_pw;

   always_ff @(posedge SYS_CLK_I) begin
      if (SYS_RST_I) begin
         ast_pw <= 11'h000;
      end else begin
         ast_pw <= r.tout_act ? ast_pw + 11'h001 : 11'h000;
      end
   end

   default clocking cb @(posedge SYS_CLK_I); endclocking
   default disable iff (SYS_RST_I);

   sequence s_start_arm;
      start_ev && r.rec_st == rtio_pkg::REC_IDLE;
   endsequence
   sequence s_arm_done;
      r.rec_st == rtio_pkg::REC_STARTING && r.rec_cnt == 32'h00000000;
   endsequence

   AST_TB_SAMPLE: assert property (f_rise[0] |-> ##[AST_TB_MIN:AST_TB_MAX] r.sample)
      else $error("Time base sample missed its window");
   AST_TOUT_WIDTH: assert property ($fell(r.tout_act) |-> ast_pw == 11'(rtio_pkg::PULSE_CYC))
      else $error("Trigger out pulse has wrong width");
   AST_FWD: assert property (trig_ev && r.ctrl.fwd_en && !r.ctrl.tdc_en && !r.tout_busy
      && !r.tout_act && !r.hold |=> r.tout_busy && r.tout_cnt == $past(dly_cyc))
      else $error("Forwarded trigger did not arm trigger out");
   AST_TDC: assert property (trig_ev && r.ctrl.tdc_en |=> TDC_O && !TRIG_MARK_O)
      else $error("Top dead centre marker not routed");
   AST_MARK: assert property (trig_ev && !r.ctrl.tdc_en |=> TRIG_MARK_O
      && r.tstamp == $past(r.ts_cnt))
      else $error("Trigger not marked or stamped");
   AST_HOLD_END: assert property (!r.rec |=> !r.hold)
      else $error("Hold persists after recording ended");
   AST_EV_DLY: assert property ($rose(r.ev_busy) |-> r.ev_cnt == $past(ev_dly))
      else $error("Event out delay wrong");
   AST_EV_REC: assert property ($stable(r.ctrl) && r.ctrl.ev_rec |-> EVENT_OUT_O == r.ev_lvl)
      else $error("Recording-active output not active high");
   AST_START: assert property (s_start_arm |=> r.rec_st == rtio_pkg::REC_STARTING ##0 !REC_O)
      else $error("Start edge did not arm recording");
   AST_RUN: assert property (s_arm_done |=> REC_O && r.rec_st == rtio_pkg::REC_RUN)
      else $error("Recording did not begin after response time");
   AST_STOP_AUTO: assert property (AUTO_I && r.rec_st == rtio_pkg::REC_RUN
      |=> r.rec_st != rtio_pkg::REC_STOPPING)
      else $error("Stop taken under automation");
   AST_IRQ: assert property (|(r.stat & r.mask) |=> IRQ_O)
      else $error("Interrupt not raised");
endmodule

`default_nettype wire

// File: verification/rtio_ext_model.sv
// Model of the external instrument that drives the four TTL input pins
`timescale 1ns/100ps
`default_nettype none
module rtio_ext_model (
   input  wire logic       clk_i,
   output var  logic [3:0] pin_o
);
   // Pull-ups hold every pin high while nothing drives it
   initial pin_o = 4'hF;
   // Low pulse of w cycles; its closing rise is the rising active edge
   task automatic pulse(input int unsigned idx, input int unsigned w);
      pin_o[idx] <= 1'b0;
      repeat (w) @(posedge clk_i);
      pin_o[idx] <= 1'b1;
   endtask
endmodule
`default_nettype wire

// File: verification/tb.sv
// Self-checking testbench of the external trigger I/O block
`timescale 1ns/100ps
`default_nettype none
module tb;
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic        psel = 1'b0;
   logic        pen = 1'b0;
   logic        pwr = 1'b0;
   logic        trig = 1'b0;
   logic        alarm = 1'b0;
   logic        auto_run = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h00000000;
   logic [31:0] prdata, rd;
   logic        pready, pslverr, err, sample, mark, tdc, rec, tout, evout, irq;
   logic [3:0]  pins;
   logic [6:0]  obs;
   int          n_fail = 0;
   int          check_count = 0;
   int          cyc;
   int          tick = 0;
   int          tk;
   assign obs = {irq, evout, tout, rec, tdc, mark, sample};
   always #12.5 clk = ~clk;
   // Edges since reset release, the base of the expected timestamp
   always @(posedge clk) begin
      if (!rst) begin
         tick <= tick + 1;
      end
   end
   rtio_top #(.REC_RESP_CYC(20)) dut_u (
      .SYS_CLK_I(clk), .SYS_RST_I(rst), .PSEL_I(psel), .PENABLE_I(pen),
      .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
      .PREADY_O(pready), .PSLVERR_O(pslverr), .EXT_TB_I(pins[0]),
      .EXT_TRIG_I(pins[1]), .EXT_START_I(pins[2]), .EXT_STOP_I(pins[3]),
      .TRIG_I(trig), .ALARM_I(alarm), .AUTO_I(auto_run), .SAMPLE_O(sample),
      .TRIG_MARK_O(mark), .TDC_O(tdc), .REC_O(rec), .TRIG_OUT_O(tout),
      .EVENT_OUT_O(evout), .IRQ_O(irq));
   rtio_ext_model ext_u (.clk_i(clk), .pin_o(pins));
   // ************************************************************
   // Tasks
   // ************************************************************
   task automatic stop_test;
      $display("checks %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      check_count++;
      if (g !== e) begin
         n_fail++;
         $display("ERROR %s expected %h seen %h", n, e, g);
      end
   endtask
   // Cycle count of the last wait must fall in lo..hi
   task automatic chk_in(input string n, input int lo, input int hi);
      check_count++;
      if (cyc < lo || cyc > hi) begin
         n_fail++;
         $display("ERROR %s expected %0d..%0d seen %0d", n, lo, hi, cyc);
      end
   endtask
   // Bounded wait for one observed output to reach a level
   task automatic waitk(input int b, input logic v, input int lim);
      cyc = 0;
      while (obs[b] !== v && cyc < lim) begin
         @(posedge clk);
         cyc++;
      end
   endtask
   // One idle cycle at the end keeps back-to-back calls apart
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pen <= 1'b0;
      pwr <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      pen <= 1'b1;
      // No cycle budget here: only the watchdog ends a stuck wait
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      pen <= 1'b0;
      @(posedge clk);
   endtask
   task automatic fire;
      trig <= 1'b1;
      @(posedge clk);
      trig <= 1'b0;
   endtask
   initial begin
      repeat (10000) @(posedge clk);
      n_fail++;
      stop_test();
   end
   initial begin
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      apb(1'b0, 8'h00, 32'h0);
      chk("ctrl", 32'(rtio_pkg::CTRL_RST), rd);
      apb(1'b0, 8'h04, 32'h0);
      chk("delay", 32'h00000204, rd);
      apb(1'b0, 8'h40, 32'h0);
      chk("slverr", 32'h1, 32'(err));
      ext_u.pulse(0, 8);
      waitk(0, 1'b1, 40);
      chk_in("tb_lat", 15, 19);
      // Let the sample pulse end before looking for a second one
      @(posedge clk);
      waitk(0, 1'b1, 30);
      chk_in("tb_once", 30, 30);
      ext_u.pulse(1, 4);
      waitk(1, 1'b1, 40);
      chk_in("glitch", 40, 40);
      ext_u.pulse(1, 24);
      waitk(1, 1'b1, 60);
      chk_in("trig_lat", 19, 40);
      tk = tick;
      apb(1'b0, 8'h08, 32'h0);
      chk("st_trig", 32'h1, 32'(rd[0]));
      apb(1'b0, 8'h08, 32'h0);
      chk("st_clr", 32'h0, 32'(rd[4:0]));
      // Stamp counts 50 ns steps from reset release
      apb(1'b0, 8'h10, 32'h0);
      cyc = int'(rd);
      chk_in("tstamp", (tk - 1) / 2, tk / 2);
      apb(1'b1, 8'h00, 32'h00000181);
      // Falling edge is active, so the marker comes inside the pulse
      fork
         ext_u.pulse(1, 40);
      join_none
      waitk(2, 1'b1, 40);
      chk_in("tdc", 19, 40);
      apb(1'b0, 8'h08, 32'h0);
      chk("st_tdc", 32'h1, 32'(rd[3]));
      // Closing rise must clear the filter before rising edges become active
      repeat (40) @(posedge clk);
      apb(1'b1, 8'h00, 32'h00000080);
      apb(1'b1, 8'h04, 32'h1);
      apb(1'b1, 8'h0C, 32'h10);
      fire();
      waitk(4, 1'b1, 80);
      chk_in("tout_dly", 40, 43);
      waitk(4, 1'b0, 600);
      chk_in("tout_hi", 500, 512);
      chk("irq_set", 32'h1, 32'(irq));
      apb(1'b0, 8'h08, 32'h0);
      chk("st_tout", 32'h10, 32'(rd[4:0]));
      @(posedge clk);
      chk("irq_clr", 32'h0, 32'(irq));
      apb(1'b1, 8'h0C, 32'h0);
      apb(1'b1, 8'h00, 32'h00000090);
      fire();
      waitk(4, 1'b0, 80);
      waitk(4, 1'b1, 600);
      chk_in("tout_lo", 500, 512);
      chk("irq_mask", 32'h0, 32'(irq));
      apb(1'b1, 8'h00, 32'h00000088);
      ext_u.pulse(1, 24);
      waitk(4, 1'b1, 100);
      chk_in("fwd", 50, 70);
      waitk(4, 1'b0, 600);
      // Start taken on its falling edge, stop on its rising edge
      apb(1'b1, 8'h00, 32'h000000E2);
      apb(1'b1, 8'h04, 32'h2);
      ext_u.pulse(2, 10);
      waitk(3, 1'b1, 60);
      chk_in("rec_on", 21, 40);
      waitk(5, 1'b1, 100);
      chk_in("ev_on", 40, 43);
      fire();
      waitk(4, 1'b1, 120);
      chk_in("hold_on", 80, 83);
      auto_run <= 1'b1;
      ext_u.pulse(3, 10);
      waitk(3, 1'b0, 40);
      chk_in("rec_auto", 40, 40);
      auto_run <= 1'b0;
      ext_u.pulse(3, 10);
      waitk(3, 1'b0, 60);
      chk_in("rec_off", 21, 40);
      chk("hold", 32'h1, 32'(tout));
      waitk(4, 1'b0, 3);
      chk_in("hold_off", 1, 2);
      waitk(5, 1'b0, 100);
      chk_in("ev_off", 36, 43);
      apb(1'b1, 8'h00, 32'h0);
      repeat (100) @(posedge clk);
      alarm <= 1'b1;
      waitk(5, 1'b0, 100);
      chk_in("alm_on", 40, 43);
      alarm <= 1'b0;
      waitk(5, 1'b1, 100);
      chk_in("alm_off", 40, 43);
      stop_test();
   end
endmodule
`default_nettype wire
